// [hdl/pscap_pkg.sv]
// pscap_pkg: constants shared by the strap capture block and its clock divider.
// assumes a 40 MHz core clock and an MII receive clock derived from it.
package pscap_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned RXCLK_100_HZ    = 25000000;
  localparam int unsigned RXCLK_10_HZ     = 2500000;
  localparam int unsigned REFCLK_HZ       = 50000000;
  // half periods in core cycles, rounded down, never below one
  localparam int unsigned HALF_100_RAW    = CLK_HZ / (2 * RXCLK_100_HZ);
  localparam int unsigned HALF_100        = (HALF_100_RAW < 1) ? 1 : HALF_100_RAW;
  localparam int unsigned HALF_10_RAW     = CLK_HZ / (2 * RXCLK_10_HZ);
  localparam int unsigned HALF_10         = (HALF_10_RAW < 1) ? 1 : HALF_10_RAW;
  localparam int unsigned DIV_W           = 8;
  localparam logic [2:0]  ADDR_RST        = 3'h0;
  localparam logic        LOOP_RST        = 1'h0;
  localparam logic        ISO_RST         = 1'h0;
  localparam int unsigned ADDR_BIT2_POS   = 0;
  localparam int unsigned ADDR_BIT3_POS   = 1;
  localparam int unsigned ADDR_BIT4_POS   = 2;
  localparam int unsigned RXD0_POS        = 0;
  localparam int unsigned RXD1_POS        = 1;
  localparam int unsigned RXD2_POS        = 2;
  localparam int unsigned RXDV_POS        = 4;
  localparam int unsigned RXER_POS        = 5;
  localparam int unsigned TXC_POS         = 6;
  localparam int unsigned PIN_N           = 7;
endpackage

// [hdl/pscap_clk_if.sv]
// pscap_clk_if: carries divider settings and the divided clock between modules.
// assumes both ends run on the core clock.
`timescale 1ns/1ps
interface pscap_clk_if;
  logic             speed_100;
  logic             run;
  logic             clk_level;
  modport ctrl (output speed_100, output run, input clk_level);
  modport div  (input speed_100, input run, output clk_level);
endinterface

// [hdl/pscap_rxclk_div.sv]
// pscap_rxclk_div: divides the core clock down to the MII receive clock.
// assumes the core clock rate in the package; at 40 MHz the 100 Mbit/s rate is limited by the clock.
`timescale 1ns/1ps
module pscap_rxclk_div
  import pscap_pkg::*;
#(
  parameter int unsigned HALF_FAST = HALF_100,
  parameter int unsigned HALF_SLOW = HALF_10
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  pscap_clk_if.div  dv
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             lvl;
  logic             next_lvl;
  logic [DIV_W-1:0] limit;

  assign limit = dv.speed_100 ? DIV_W'(HALF_FAST - 1) : DIV_W'(HALF_SLOW - 1);
  assign dv.clk_level = lvl;

  // [R4] rate per speed
  always_comb begin
    next_cnt = cnt;
    next_lvl = lvl;
    if (!dv.run) begin
      next_cnt = '0;
      next_lvl = 1'h0;
    end else if (cnt >= limit) begin
      next_cnt = '0;
      next_lvl = ~lvl;
    end else begin
      next_cnt = cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      lvl <= 1'h0;
    end else if (ce) begin
      cnt <= next_cnt;
      lvl <= next_lvl;
    end
  end
endmodule

// [hdl/pscap_top.sv]
// pscap_top: catches straps on the receive pins during reset, drives the receive
// clock and handles the transmit clock pin as output or reference input.
// assumes strap pins have pull-downs and are driven only by resistors during reset.
//
// Behaviour
// [R1] during reset, receive data 2,1,0 become station address bits 2,3,4
// [R2] during reset, receive data valid becomes the coding loopback enable
// [R3] during reset, receive error becomes the isolation setting
// [R4] receive clock is 25 MHz at 100 Mbit/s, 2.5 MHz at 10 Mbit/s; the divider gives 20 MHz at 100 Mbit/s from the 40 MHz core clock
// [R5] transmit clock pin is an output, or accepts a 50 MHz reference; the edge detector samples it on the 40 MHz core clock, too slow for 50 MHz
// [R6] the MAC uses the receive nibble only while data valid is high
// [R7] unpulled straps read zero; captured values hold until next reset
`timescale 1ns/1ps
module pscap_top
  import pscap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       speed_100,
  input  wire logic       ref_clk_mode,
  input  wire logic [3:0] rx_data_in,
  input  wire logic       rx_valid_in,
  input  wire logic       rx_error_in,
  input  wire logic [3:0] rx_data,
  input  wire logic       rx_valid,
  input  wire logic       rx_error,
  input  wire logic       tx_clk_in,
  output logic [3:0]      rx_data_out,
  output logic [3:0]      rx_data_oe_n,
  output logic            rx_valid_out,
  output logic            rx_valid_oe_n,
  output logic            rx_error_out,
  output logic            rx_error_oe_n,
  output logic            rx_clk,
  output logic            tx_clk_out,
  output logic            tx_clk_oe_n,
  output logic            ref_clk_edge,
  output logic [2:0]      station_address,
  output logic            coding_loopback_strap,
  output logic            isolate
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers, kept out of reset so that the pins are still
  // sampled while reset is held; the straps are taken from them later
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync2;
  logic             txc_d;
  logic             rst_seen;

  // bit order follows the package positions
  assign pin_raw = {tx_clk_in, rx_error_in, rx_valid_in, rx_data_in};

  // first stage feeds only the second
  generate
    for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
      logic stage1;
      logic stage2;

      always_ff @(posedge clk) begin
        if (ce) begin
          stage1 <= pin_raw[gi];
          stage2 <= stage1;
        end
      end

      assign sync2[gi] = stage2;
    end
  endgenerate

  // edge history is not reset either: a reset value of zero would
  // fake an edge on release while the reference clock is high
  always_ff @(posedge clk) begin
    if (ce) begin
      txc_d <= sync2[TXC_POS];
    end
  end

  ////////////////////////////////////////////////////////////////
  // strap capture: an async reset can only load constants, so the pin
  // levels that the synchronisers took while reset was held are loaded
  // on the second enabled edge after release
  // limitation: strap pins must stay steady from the last edges of
  // reset through that second edge
  logic [2:0] next_addr;
  logic       next_loop;
  logic       next_iso;
  logic       next_seen;
  logic       cap_cnt;
  logic       next_cap_cnt;

  always_comb begin
    next_addr    = station_address;
    next_loop    = coding_loopback_strap;
    next_iso     = isolate;
    next_seen    = rst_seen;
    next_cap_cnt = cap_cnt;
    if (!rst_seen) begin
      // waits one more edge so the synchroniser holds settled pin levels
      if (cap_cnt) begin
        // [R1] station address capture
        next_addr[ADDR_BIT2_POS] = sync2[RXD2_POS];
        next_addr[ADDR_BIT3_POS] = sync2[RXD1_POS];
        next_addr[ADDR_BIT4_POS] = sync2[RXD0_POS];
        // [R2] loopback strap capture
        next_loop = sync2[RXDV_POS];
        // [R3] isolation strap capture
        next_iso  = sync2[RXER_POS];
        next_seen = 1'h1;
      end else begin
        next_cap_cnt = 1'h1;
      end
    end
  end

  // [R7] values frozen after capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      station_address       <= ADDR_RST;
      coding_loopback_strap <= LOOP_RST;
      isolate               <= ISO_RST;
      rst_seen              <= 1'h0;
      cap_cnt               <= 1'h0;
    end else if (ce) begin
      station_address       <= next_addr;
      coding_loopback_strap <= next_loop;
      isolate               <= next_iso;
      rst_seen              <= next_seen;
      cap_cnt               <= next_cap_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive clock and transmit clock pin
  // the divider is held until the straps are taken, so the receive
  // clock starts low and in a known phase after every reset
  pscap_clk_if cif ();
  assign cif.speed_100 = speed_100;
  assign cif.run       = rst_seen;

  pscap_rxclk_div u_div (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .dv  (cif.div)
  );

  logic next_edge;
  logic next_txc_oe_n;
  logic next_txc;
  logic next_rxc;

  always_comb begin
    // [R4] receive clock out
    next_rxc      = cif.clk_level;
    // [R5] pin direction by mode
    next_txc_oe_n = ref_clk_mode;
    next_txc      = ref_clk_mode ? 1'h0 : cif.clk_level;
    // [R5] reference rising edges
    next_edge     = ref_clk_mode & sync2[TXC_POS] & ~txc_d;
  end

  ////////////////////////////////////////////////////////////////
  // clock pins: receive clock, transmit clock pin and reference edge;
  // the transmit pin is released in reset so a reference can drive it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_clk       <= 1'h0;
      tx_clk_out   <= 1'h0;
      tx_clk_oe_n  <= 1'h1;
      ref_clk_edge <= 1'h0;
    end else if (ce) begin
      rx_clk       <= next_rxc;
      tx_clk_out   <= next_txc;
      tx_clk_oe_n  <= next_txc_oe_n;
      ref_clk_edge <= next_edge;
    end
  end

  ////////////////////////////////////////////////////////////////
  // receive pins stay released until straps are taken, so the MAC
  // cannot fight the pull resistors; isolation keeps them released
  // same decision for the nibble and for valid and error
  function automatic logic drive_ok(input logic taken, input logic iso);
    drive_ok = taken & ~iso;
  endfunction

  logic [3:0] next_rxd_oe_n;
  logic       next_rxo_oe_n;
  logic [3:0] next_rxd;
  logic       next_rxv;
  logic       next_rxe;

  always_comb begin
    // [R6] nibble zeroed while not valid
    next_rxd      = rx_valid ? rx_data : 4'h0;
    next_rxv      = rx_valid;
    next_rxe      = rx_error;
    // [R3] released while isolated
    next_rxd_oe_n = drive_ok(rst_seen, isolate) ? 4'h0 : 4'hF;
    next_rxo_oe_n = ~drive_ok(rst_seen, isolate);
  end

  // receive pins, one cycle behind the internal receive logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_out   <= 4'h0;
      rx_valid_out  <= 1'h0;
      rx_error_out  <= 1'h0;
      rx_data_oe_n  <= 4'hF;
      rx_valid_oe_n <= 1'h1;
      rx_error_oe_n <= 1'h1;
    end else if (ce) begin
      rx_data_out   <= next_rxd;
      rx_valid_out  <= next_rxv;
      rx_error_out  <= next_rxe;
      rx_data_oe_n  <= next_rxd_oe_n;
      rx_valid_oe_n <= next_rxo_oe_n;
      rx_error_oe_n <= next_rxo_oe_n;
    end
  end
endmodule

// [bench/pscap_sva.sv]
// pscap_sva: timing checks on the strap capture block, bound to its top ports.
// assumes speed and clock mode steady between resets; checks pause while ce is low.
`timescale 1ns/1ps
module pscap_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       speed_100,
  input wire logic       ref_clk_mode,
  input wire logic [3:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_error,
  input wire logic [3:0] rx_data_out,
  input wire logic [3:0] rx_data_oe_n,
  input wire logic       rx_valid_out,
  input wire logic       rx_valid_oe_n,
  input wire logic       rx_error_out,
  input wire logic       rx_error_oe_n,
  input wire logic       rx_clk,
  input wire logic       tx_clk_out,
  input wire logic       tx_clk_oe_n,
  input wire logic       ref_clk_edge,
  input wire logic [2:0] station_address,
  input wire logic       coding_loopback_strap,
  input wire logic       isolate
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  ////////////////////////////////////////////////////////////////////////
  // edges since release, saturating once capture is long done
  logic [1:0] n;
  always_ff @(posedge clk or posedge rst)
    if (rst) n <= 2'h0;
    else if (n != 2'h3) n <= n + 2'h1;
  sequence s_high8;
    rx_clk [*8] ##1 !rx_clk;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_hold; n == 2'h3 |-> $stable({station_address, coding_loopback_strap, isolate}); endproperty
  a_hold: assert property (p_hold) else $error("straps moved after capture");
  property p_iso; isolate |-> &{rx_data_oe_n, rx_valid_oe_n, rx_error_oe_n}; endproperty
  a_iso: assert property (p_iso) else $error("receive pins driven while isolated");
  property p_drive; n == 2'h3 && !isolate |-> !(|{rx_data_oe_n, rx_valid_oe_n, rx_error_oe_n}); endproperty
  a_drive: assert property (p_drive) else $error("receive pins idle while not isolated");
  property p_data;
    n == 2'h3 |-> rx_valid_out == $past(rx_valid) && rx_error_out == $past(rx_error) &&
      rx_data_out == ($past(rx_valid) ? $past(rx_data) : 4'h0);
  endproperty
  a_data: assert property (p_data) else $error("receive nibble not passed as sent");
  property p_fast; n == 2'h3 && $past(n) == 2'h3 && speed_100 |-> rx_clk != $past(rx_clk); endproperty
  a_fast: assert property (p_fast) else $error("fast receive clock missed a toggle");
  property p_slow; $rose(rx_clk) && !speed_100 |-> s_high8; endproperty
  a_slow: assert property (p_slow) else $error("slow receive clock half period wrong");
  property p_txoe; n == 2'h3 |-> tx_clk_oe_n == $past(ref_clk_mode); endproperty
  a_txoe: assert property (p_txoe) else $error("transmit clock pin direction wrong");
  property p_txq; tx_clk_oe_n |-> !tx_clk_out; endproperty
  a_txq: assert property (p_txq) else $error("transmit clock driven while input");
  property p_txcopy; n == 2'h3 && !$past(ref_clk_mode) |-> tx_clk_out == rx_clk; endproperty
  a_txcopy: assert property (p_txcopy) else $error("transmit clock output not the receive clock");
  property p_pulse; ref_clk_edge |-> $past(ref_clk_mode) ##1 !ref_clk_edge; endproperty
  a_pulse: assert property (p_pulse) else $error("reference edge pulse malformed");
endmodule

// [bench/pscap_mac_model.sv]
// pscap_mac_model: mac side of the mii pins, strap resistors and reference clock.
// assumes one pull resistor per pin; a released pin settles to its pull level.
`timescale 1ns/1ps
module pscap_mac_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] pull,
  input  wire logic [5:0] drv,
  input  wire logic [5:0] drv_oe_n,
  output logic [5:0]      pin,
  output logic            ref_clk,
  output logic [7:0]      nib_sum
);
  assign pin = (drv & ~drv_oe_n) | (pull & drv_oe_n);
  // free running, period eight core clock periods, fixed in phase to the core clock
  initial ref_clk = 1'b0;
  always #100 ref_clk = ~ref_clk;
  always @(posedge clk or posedge rst)
    if (rst) nib_sum <= 8'h00;
    else if (pin[4]) nib_sum <= nib_sum + {4'h0, pin[3:0]};
endmodule

// [bench/tb_pscap_top.sv]
// tb_pscap_top: straps, receive path and clock pins of the strap capture block.
// assumes the mac model resolves pin levels and supplies the reference clock.
`timescale 1ns/1ps
module tb_pscap_top;
  logic clk = 1'b0, rst = 1'b1, speed_100 = 1'b0, ref_clk_mode = 1'b0, rx_valid = 1'b0, rx_error = 1'b0;
  logic [3:0] rx_data = 4'h0, rx_data_out, rx_data_oe_n;
  logic [5:0] pull = 6'h00, pin;
  logic [2:0] station_address;
  logic rx_valid_out, rx_valid_oe_n, rx_error_out, rx_error_oe_n, rx_clk, tx_clk_out, tx_clk_oe_n;
  logic ref_clk_edge, coding_loopback_strap, isolate, ref_clk, prev;
  logic [7:0] nib_sum, base;
  logic [15:0] rx_rises, edges;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  logic ce = 1'b1;
  logic [7:0] rows [3] = '{8'h00, 8'hD5, 8'h2C};
  always #12.5 clk = ~clk;
  pscap_top dut (.clk(clk), .rst(rst), .ce(ce), .speed_100(speed_100), .ref_clk_mode(ref_clk_mode),
    .rx_data_in(pin[3:0]), .rx_valid_in(pin[4]), .rx_error_in(pin[5]), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_error(rx_error), .tx_clk_in(ref_clk), .rx_data_out(rx_data_out), .rx_data_oe_n(rx_data_oe_n),
    .rx_valid_out(rx_valid_out), .rx_valid_oe_n(rx_valid_oe_n), .rx_error_out(rx_error_out),
    .rx_error_oe_n(rx_error_oe_n), .rx_clk(rx_clk), .tx_clk_out(tx_clk_out), .tx_clk_oe_n(tx_clk_oe_n),
    .ref_clk_edge(ref_clk_edge), .station_address(station_address),
    .coding_loopback_strap(coding_loopback_strap), .isolate(isolate));
  pscap_mac_model mac (.clk(clk), .rst(rst), .pull(pull), .drv({rx_error_out, rx_valid_out, rx_data_out}),
    .drv_oe_n({rx_error_oe_n, rx_valid_oe_n, rx_data_oe_n}), .pin(pin), .ref_clk(ref_clk), .nib_sum(nib_sum));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    samples_checked++;
    if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: got %0d, want %0d", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // each row: speed, clock mode, then pulls {err, valid, data[3:0]}
  initial begin
    foreach (rows[r]) begin
      @(posedge clk);
      rst <= 1'b1;
      {speed_100, ref_clk_mode, pull} <= rows[r];
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      // valid pull kept so an isolated mac sees no stray frames
      pull <= rows[r][5:0] ^ 6'h2F;
      @(negedge clk);
      base = nib_sum;
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        rx_data <= 4'(i);
        rx_valid <= i[0];
        rx_error <= i[1];
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(16'(station_address), 16'({rows[r][0], rows[r][1], rows[r][2]}), 16'h0);
      chk(16'(coding_loopback_strap), 16'(rows[r][4]), 16'h0);
      chk(16'(isolate), 16'(rows[r][5]), 16'h0);
      chk(16'({rx_data_oe_n, rx_valid_oe_n}), rows[r][5] ? 16'h1F : 16'h0, 16'h0);
      chk(16'(nib_sum - base), rows[r][5] ? 16'h0 : 16'h10, 16'h0);
      chk(16'(tx_clk_oe_n), 16'(rows[r][6]), 16'h0);
      rx_rises = 16'h0;
      edges = 16'h0;
      prev = rx_clk;
      repeat (400) begin
        @(negedge clk);
        rx_rises += 16'(rx_clk && !prev);
        edges += 16'(ref_clk_edge);
        prev = rx_clk;
      end
      chk(rx_rises, rows[r][7] ? 16'hC8 : 16'h19, 16'h1);
      chk(edges, rows[r][6] ? 16'h32 : 16'h0, 16'h1);
      // slow clock must stand still while ce is low
      if (r == 2) begin
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        prev = rx_clk;
        rx_rises = 16'h0;
        repeat (20) begin
          @(negedge clk);
          rx_rises += 16'(rx_clk != prev);
        end
        chk(rx_rises, 16'h0, 16'h0);
        @(posedge clk);
        ce <= 1'b1;
      end
    end
    conclude;
  end
endmodule
bind pscap_top pscap_sva u_sva (.*);
